// *** ebmrg_mcu_model.sv ***
// Purpose: far side model, the processor pins seen by the glue block
// Assumes: one clock; pipe strobe is made only on request
// Notes: data bus resolved with pull-ups; idle pipe bits toggle
`timescale 1ns/100ps
`default_nettype none

module ebmrg_mcu_model (
    input wire logic i_sys_clk,
    input wire logic [15:0] i_data_o,
    input wire logic [15:0] i_data_oe_n,
    output logic [15:0] o_bus,
    output var logic o_pipe_strobe,
    output var logic [1:0] o_pipe_status
);
    // ========================================
    // open-drain bus, released lines float high
    assign o_bus = (~i_data_oe_n & i_data_o) | i_data_oe_n;

    initial begin
        o_pipe_strobe = 1'h0;
        o_pipe_status = 2'h0;
    end

    // ========================================
    // one strobe pulse; bits change after it so stale values do not pass
    task automatic pulse(input logic [1:0] bits);
        @(posedge i_sys_clk);
        #1;
        o_pipe_strobe = 1'h1;
        o_pipe_status = bits;
        @(posedge i_sys_clk);
        #1;
        o_pipe_strobe = 1'h0;
        o_pipe_status = ~bits;
    endtask
endmodule // ebmrg_mcu_model

`default_nettype wire

// *** ebmrg_pipe_latch.sv ***
// Purpose: demultiplex pipe status and latch both debug status signals
// Assumes: strobe and pipe inputs synchronous to the clock
// Notes: narrow family carries both signals on pipe bit 0 in two phases
`timescale 1ns/100ps
`default_nettype none

module ebmrg_pipe_latch (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_family,
    input wire logic i_pipe_strobe,
    input wire logic [1:0] i_pipe_status,
    output logic o_latched_debug_out,
    output logic o_latched_debug_in
);

    typedef struct packed {
        logic strobe_prev;
        logic phase;
        logic lat_out;
        logic lat_in;
    } ebmrg_pipe_st_t;

    ebmrg_pipe_st_t st_r;
    ebmrg_pipe_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.strobe_prev = i_pipe_strobe;
        if (i_pipe_strobe && !st_r.strobe_prev) begin
            if (i_family == ebmrg_pkg::FAMILY_WIDE) begin
                st_nxt.lat_out = i_pipe_status[0];
                st_nxt.lat_in = i_pipe_status[1];
                st_nxt.phase = 1'h0;
            end else begin
                // one bit, two phases: out first, then in
                if (!st_r.phase) begin
                    st_nxt.lat_out = i_pipe_status[0];
                end else begin
                    st_nxt.lat_in = i_pipe_status[0];
                end
                st_nxt.phase = ~st_r.phase;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            st_r <= '{1'h0, 1'h0, ebmrg_pkg::RST_LATCH, ebmrg_pkg::RST_LATCH};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_latched_debug_out = st_r.lat_out;
    assign o_latched_debug_in = st_r.lat_in;

endmodule // ebmrg_pipe_latch

`default_nettype wire

// *** ebmrg_pkg.sv ***
// Purpose: shared constants for the memory and reset glue block
// Assumes: jumper selections arrive as static encoded inputs
// Notes: none
`default_nettype none

package ebmrg_pkg;

    // ========================================
    // widths
    localparam int DATA_W = 16;
    localparam int ROM_ADDR_HI_W = 5;

    // ========================================
    // pseudo rom memory type selection
    typedef enum logic [1:0] {
        MTYPE_RAM = 2'h0,
        MTYPE_EPROM = 2'h1,
        MTYPE_FLASH = 2'h2,
        MTYPE_BAD = 2'h3
    } ebmrg_mtype_t;

    // ========================================
    // pseudo rom size selection, size doubling each step from 32k x 8
    typedef enum logic [2:0] {
        MSIZE_32K = 3'h0,
        MSIZE_64K = 3'h1,
        MSIZE_128K = 3'h2,
        MSIZE_256K = 3'h3,
        MSIZE_512K = 3'h4
    } ebmrg_msize_t;

    // ========================================
    // processor family selection for the pipe demux
    localparam logic FAMILY_WIDE = 1'h0;
    localparam logic FAMILY_NARROW = 1'h1;

    // ========================================
    // reset values
    localparam logic [15:0] RST_DATA_OE_N = 16'hFFFF;
    localparam logic RST_PIN_OE_N = 1'h1;
    localparam logic RST_LED = 1'h0;
    localparam logic RST_LATCH = 1'h0;

endpackage : ebmrg_pkg

`default_nettype wire

// *** ebmrg_top.sv ***
// Purpose: memory socket routing and reset configuration glue
// Assumes: all configuration inputs are static; one 250 MHz clock
// Notes: open-drain pins are split into out, active-low enable
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - drive reset data on bus while reset
// - each data line level set by input
// - chip select zero writes ram two
// - chip select three writes ram one
// - chip select five enables ram reads
// - rom write strobe follows rom memory type
// - rom address lines follow size selection
// - boot select and fast ram select routed
// - clock mode pin low in reset when configured
// - bus error pin low in reset when configured
// - rom writes only in debug when protected
// - optionally force array address bit nineteen low
// - latch both debug status signals for analyzer
// - error indicator on invalid rom configuration
// - insertion input lights error, not reset
// - run indicator on only in foreground
// - invalid rom configuration holds board reset
module ebmrg_top #(
    parameter int DATA_W = ebmrg_pkg::DATA_W
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_reset_line_n,
    input wire logic i_bdm_active,
    input wire logic [DATA_W-1:0] i_reset_data_cfg,
    input wire logic i_clk_mode_low_cfg,
    input wire logic i_bus_err_low_cfg,
    input wire logic i_cs0_we_en,
    input wire logic i_cs3_we_en,
    input wire logic i_cs5_oe_en,
    input wire logic i_write_protect_en,
    input wire logic i_addr19_disconnect,
    input wire logic [1:0] i_memory_type_select,
    input wire logic [2:0] i_memory_size_select,
    input wire logic i_family,
    input wire logic i_chip_select_zero_n,
    input wire logic i_chip_select_three_n,
    input wire logic i_chip_select_five_n,
    input wire logic i_boot_chip_select_n,
    input wire logic i_fast_ram_chip_select_n,
    input wire logic i_alt_ram2_we_n,
    input wire logic i_alt_ram1_we_n,
    input wire logic i_alt_ram_oe_n,
    input wire logic i_write_n,
    input wire logic i_read_n,
    input wire logic [18:15] i_addr_hi,
    input wire logic i_address_bit_nineteen,
    input wire logic i_error_insertion_input_n,
    input wire logic i_pipe_strobe,
    input wire logic [1:0] i_pipe_status,
    output logic [DATA_W-1:0] o_data_o,
    output logic [DATA_W-1:0] o_data_oe_n,
    output logic o_clock_mode_pin_o,
    output logic o_clock_mode_pin_oe_n,
    output logic o_bus_error_pin_o,
    output logic o_bus_error_pin_oe_n,
    output logic o_board_reset_o,
    output logic o_board_reset_oe_n,
    output logic o_ram2_we_n,
    output logic o_ram1_we_n,
    output logic o_ram_oe_n,
    output logic o_rom_ce_n,
    output logic o_rom_we_n,
    output logic o_rom_oe_n,
    output logic [ebmrg_pkg::ROM_ADDR_HI_W-1:0] o_rom_addr_hi,
    output logic o_fast_ram_cs_n,
    output logic o_mem_address_bit_nineteen,
    output logic o_error_indicator,
    output logic o_run_indicator,
    output logic o_latched_debug_out,
    output logic o_latched_debug_in
);

    // ========================================
    // configuration checks
    function automatic logic cfg_invalid(input logic [1:0] mtype, input logic [2:0] msize);
        logic bad;
        bad = 1'h0;
        if (mtype == ebmrg_pkg::MTYPE_BAD) begin
            bad = 1'h1;
        end
        if (msize > ebmrg_pkg::MSIZE_512K) begin
            bad = 1'h1;
        end
        // static rams only come in 32k, 128k and 512k
        if (mtype == ebmrg_pkg::MTYPE_RAM &&
            (msize == ebmrg_pkg::MSIZE_64K || msize == ebmrg_pkg::MSIZE_256K)) begin
            bad = 1'h1;
        end
        return bad;
    endfunction

    logic cfg_bad;
    assign cfg_bad = cfg_invalid(i_memory_type_select, i_memory_size_select);

    // ========================================
    // registered state
    typedef struct packed {
        logic [DATA_W-1:0] data_oe_n;
        logic clk_mode_oe_n;
        logic bus_err_oe_n;
        logic rst_oe_n;
        logic err_led;
        logic run_led;
    } ebmrg_state_t;

    ebmrg_state_t st_r;
    ebmrg_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // pull-ups give the high state; only low bits are driven
        st_nxt.data_oe_n = i_reset_line_n ? {DATA_W{1'h1}} : i_reset_data_cfg;
        st_nxt.clk_mode_oe_n = ~(~i_reset_line_n & i_clk_mode_low_cfg);
        st_nxt.bus_err_oe_n = ~(~i_reset_line_n & i_bus_err_low_cfg);
        st_nxt.rst_oe_n = ~cfg_bad;
        st_nxt.err_led = cfg_bad | ~i_error_insertion_input_n;
        st_nxt.run_led = i_reset_line_n & ~i_bdm_active;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            st_r <= '{ebmrg_pkg::RST_DATA_OE_N, ebmrg_pkg::RST_PIN_OE_N,
                      ebmrg_pkg::RST_PIN_OE_N, ebmrg_pkg::RST_PIN_OE_N,
                      ebmrg_pkg::RST_LED, ebmrg_pkg::RST_LED};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_data_o = {DATA_W{1'h0}};
    assign o_data_oe_n = st_r.data_oe_n;
    assign o_clock_mode_pin_o = 1'h0;
    assign o_clock_mode_pin_oe_n = st_r.clk_mode_oe_n;
    assign o_bus_error_pin_o = 1'h0;
    assign o_bus_error_pin_oe_n = st_r.bus_err_oe_n;
    assign o_board_reset_o = 1'h0;
    assign o_board_reset_oe_n = st_r.rst_oe_n;
    assign o_error_indicator = st_r.err_led;
    assign o_run_indicator = st_r.run_led;

    // ========================================
    // chip select routing, combinational
    assign o_ram2_we_n = i_cs0_we_en ? i_chip_select_zero_n : i_alt_ram2_we_n;
    assign o_ram1_we_n = i_cs3_we_en ? i_chip_select_three_n : i_alt_ram1_we_n;
    assign o_ram_oe_n = i_cs5_oe_en ? i_chip_select_five_n : i_alt_ram_oe_n;
    assign o_rom_ce_n = i_boot_chip_select_n;
    assign o_fast_ram_cs_n = i_fast_ram_chip_select_n;

    logic addr19;
    assign addr19 = i_addr19_disconnect ? 1'h0 : i_address_bit_nineteen;
    assign o_mem_address_bit_nineteen = addr19;

    // eprom takes no writes; protection allows them only in debug
    logic rom_wr_ok;
    always_comb begin
        rom_wr_ok = 1'h1;
        if (i_memory_type_select != ebmrg_pkg::MTYPE_RAM &&
            i_memory_type_select != ebmrg_pkg::MTYPE_FLASH) begin
            rom_wr_ok = 1'h0;
        end
        if (i_write_protect_en && !i_bdm_active) begin
            rom_wr_ok = 1'h0;
        end
    end
    assign o_rom_we_n = i_write_n | i_boot_chip_select_n | ~rom_wr_ok;
    assign o_rom_oe_n = i_read_n | i_boot_chip_select_n;

    // address lines above the device size are held low
    logic [ebmrg_pkg::ROM_ADDR_HI_W-1:0] rom_mask;
    always_comb begin
        unique case (i_memory_size_select)
            ebmrg_pkg::MSIZE_32K: rom_mask = 5'h00;
            ebmrg_pkg::MSIZE_64K: rom_mask = 5'h01;
            ebmrg_pkg::MSIZE_128K: rom_mask = 5'h03;
            ebmrg_pkg::MSIZE_256K: rom_mask = 5'h07;
            ebmrg_pkg::MSIZE_512K: rom_mask = 5'h0F;
            default: rom_mask = 5'h00;
        endcase
    end
    assign o_rom_addr_hi = {addr19, i_addr_hi} & rom_mask;

    // ========================================
    // pipe status demux
    ebmrg_pipe_latch u_pipe (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_family(i_family),
        .i_pipe_strobe(i_pipe_strobe),
        .i_pipe_status(i_pipe_status),
        .o_latched_debug_out(o_latched_debug_out),
        .o_latched_debug_in(o_latched_debug_in)
    );

    // ========================================
    // assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    a_data_drive_cfg: assert property (
        !i_reset_line_n |=> o_data_oe_n == $past(i_reset_data_cfg))
        else $error("reset data not driven from configuration");
    a_data_release: assert property (
        i_reset_line_n |=> o_data_oe_n == {DATA_W{1'h1}})
        else $error("data bus driven outside reset");
    a_ram2_we_route: assert property (
        i_cs0_we_en |-> o_ram2_we_n == i_chip_select_zero_n)
        else $error("ram two write enable not from chip select zero");
    a_ram_oe_route: assert property (
        !i_cs5_oe_en |-> o_ram_oe_n == i_alt_ram_oe_n)
        else $error("ram output enable not from alternate");
    a_clk_mode_drive: assert property (
        (!i_reset_line_n && i_clk_mode_low_cfg) |=> !o_clock_mode_pin_oe_n)
        else $error("clock mode pin not driven low in reset");
    a_bus_error_pin_release: assert property (
        (i_reset_line_n || !i_bus_err_low_cfg) |=> o_bus_error_pin_oe_n)
        else $error("bus error pin driven when not configured");
    a_rom_protect: assert property (
        (i_write_protect_en && !i_bdm_active) |-> o_rom_we_n)
        else $error("rom write outside debug mode");
    a_addr19_low: assert property (
        i_addr19_disconnect |-> !o_mem_address_bit_nineteen && !o_rom_addr_hi[4])
        else $error("address bit nineteen not forced low");
    a_err_led_cfg: assert property (
        cfg_bad |=> o_error_indicator && !o_board_reset_oe_n)
        else $error("invalid configuration not flagged");
    a_insert_no_reset: assert property (
        (!i_error_insertion_input_n && !cfg_bad) |=> o_error_indicator && o_board_reset_oe_n)
        else $error("error insertion misbehaves");
    a_run_led: assert property (
        (!i_reset_line_n || i_bdm_active) |=> !o_run_indicator)
        else $error("run indicator lit in reset or debug");
    a_run_led_on: assert property (
        (i_reset_line_n && !i_bdm_active) |=> o_run_indicator)
        else $error("run indicator dark in foreground");
    a_clk_mode_release: assert property (
        (i_reset_line_n || !i_clk_mode_low_cfg) |=> o_clock_mode_pin_oe_n)
        else $error("clock mode pin driven when not configured");
    a_bus_error_pin_drive: assert property (
        (!i_reset_line_n && i_bus_err_low_cfg) |=> !o_bus_error_pin_oe_n)
        else $error("bus error pin not driven low in reset");
    a_err_led_off: assert property (
        (!cfg_bad && i_error_insertion_input_n) |=> !o_error_indicator && o_board_reset_oe_n)
        else $error("error flagged on valid configuration");
    a_bad_type_flag: assert property (
        (i_memory_type_select == ebmrg_pkg::MTYPE_BAD) |=> o_error_indicator && !o_board_reset_oe_n)
        else $error("invalid memory type not flagged");
    a_bad_size_flag: assert property (
        (i_memory_size_select > ebmrg_pkg::MSIZE_512K) |=> o_error_indicator && !o_board_reset_oe_n)
        else $error("invalid memory size not flagged");

    // ========================================
    // assertions on the chip select and address bit nineteen routing
    a_ram2_we_alt: assert property (
        !i_cs0_we_en |-> o_ram2_we_n == i_alt_ram2_we_n)
        else $error("ram two write enable not from alternate");
    a_ram1_we_route: assert property (
        i_cs3_we_en |-> o_ram1_we_n == i_chip_select_three_n)
        else $error("ram one write enable not from chip select three");
    a_ram1_we_alt: assert property (
        !i_cs3_we_en |-> o_ram1_we_n == i_alt_ram1_we_n)
        else $error("ram one write enable not from alternate");
    a_ram_oe_cs5: assert property (
        i_cs5_oe_en |-> o_ram_oe_n == i_chip_select_five_n)
        else $error("ram output enable not from chip select five");
    a_rom_ce_route: assert property (
        o_rom_ce_n == i_boot_chip_select_n)
        else $error("rom chip enable not from boot select");
    a_fast_cs_route: assert property (
        o_fast_ram_cs_n == i_fast_ram_chip_select_n)
        else $error("fast ram select not routed");
    a_addr19_pass: assert property (
        !i_addr19_disconnect |-> o_mem_address_bit_nineteen == i_address_bit_nineteen)
        else $error("address bit nineteen not passed through");

    // ========================================
    // assertions on the rom socket controls
    a_eprom_no_write: assert property (
        (i_memory_type_select == ebmrg_pkg::MTYPE_EPROM) |-> o_rom_we_n)
        else $error("write strobe reached eprom");
    a_rom_we_free: assert property (
        (!i_write_protect_en && i_memory_type_select == ebmrg_pkg::MTYPE_FLASH &&
         !i_write_n && !i_boot_chip_select_n) |-> !o_rom_we_n)
        else $error("unprotected flash write blocked");
    a_rom_we_bdm: assert property (
        (i_write_protect_en && i_bdm_active && i_memory_type_select == ebmrg_pkg::MTYPE_FLASH &&
         !i_write_n && !i_boot_chip_select_n) |-> !o_rom_we_n)
        else $error("debug mode flash write blocked");
    a_ram_rom_write: assert property (
        (!i_write_protect_en && i_memory_type_select == ebmrg_pkg::MTYPE_RAM &&
         !i_write_n && !i_boot_chip_select_n) |-> !o_rom_we_n)
        else $error("ram write in rom socket blocked");
    a_rom_read_route: assert property (
        (!i_read_n && !i_boot_chip_select_n) |-> !o_rom_oe_n)
        else $error("rom read not enabled");
    a_rom_idle: assert property (
        i_boot_chip_select_n |-> o_rom_oe_n && o_rom_we_n)
        else $error("deselected rom socket strobed");
    a_rom_addr_32k: assert property (
        (i_memory_size_select == ebmrg_pkg::MSIZE_32K) |-> o_rom_addr_hi == 5'h00)
        else $error("high rom address lines not held for smallest size");
    a_rom_addr_64k: assert property (
        (i_memory_size_select == ebmrg_pkg::MSIZE_64K) |-> o_rom_addr_hi == {4'h0, i_addr_hi[15]})
        else $error("rom address lines wrong for second size");
    a_rom_addr_512k: assert property (
        (i_memory_size_select == ebmrg_pkg::MSIZE_512K) |-> o_rom_addr_hi[3:0] == i_addr_hi)
        else $error("rom address lines wrong for largest size");

endmodule // ebmrg_top

`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the memory and reset glue block
// Assumes: inputs driven 1 ns after the rising edge
// Notes: registered outputs checked one edge after their cause
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic i_sys_clk = 1'h0, i_rstn, i_reset_line_n, i_bdm_active, i_clk_mode_low_cfg;
    logic i_bus_err_low_cfg, i_cs0_we_en, i_cs3_we_en, i_cs5_oe_en, i_write_protect_en;
    logic i_addr19_disconnect, i_family, i_chip_select_zero_n, i_chip_select_three_n;
    logic i_chip_select_five_n, i_boot_chip_select_n, i_fast_ram_chip_select_n;
    logic i_alt_ram2_we_n, i_alt_ram1_we_n, i_alt_ram_oe_n, i_write_n, i_read_n;
    logic i_address_bit_nineteen, i_error_insertion_input_n;
    logic [15:0] i_reset_data_cfg;
    logic [1:0] i_memory_type_select;
    logic [2:0] i_memory_size_select;
    logic [18:15] i_addr_hi;
    wire logic i_pipe_strobe;
    wire logic [1:0] i_pipe_status;
    wire logic [15:0] o_data_o, o_data_oe_n, bus;
    wire logic o_clock_mode_pin_o, o_clock_mode_pin_oe_n, o_bus_error_pin_o;
    wire logic o_bus_error_pin_oe_n, o_board_reset_o, o_board_reset_oe_n, o_ram2_we_n;
    wire logic o_ram1_we_n, o_ram_oe_n, o_rom_ce_n, o_rom_we_n, o_rom_oe_n;
    wire logic [4:0] o_rom_addr_hi;
    wire logic o_fast_ram_cs_n, o_mem_address_bit_nineteen, o_error_indicator;
    wire logic o_run_indicator, o_latched_debug_out, o_latched_debug_in;
    int errors = 0;
    int checked = 0;

    always #2 i_sys_clk = ~i_sys_clk;

    ebmrg_top dut_u (.i_sys_clk, .i_rstn, .i_reset_line_n, .i_bdm_active, .i_reset_data_cfg,
        .i_clk_mode_low_cfg, .i_bus_err_low_cfg, .i_cs0_we_en, .i_cs3_we_en, .i_cs5_oe_en,
        .i_write_protect_en, .i_addr19_disconnect, .i_memory_type_select,
        .i_memory_size_select, .i_family, .i_chip_select_zero_n, .i_chip_select_three_n,
        .i_chip_select_five_n, .i_boot_chip_select_n, .i_fast_ram_chip_select_n,
        .i_alt_ram2_we_n, .i_alt_ram1_we_n, .i_alt_ram_oe_n, .i_write_n, .i_read_n,
        .i_addr_hi, .i_address_bit_nineteen, .i_error_insertion_input_n, .i_pipe_strobe,
        .i_pipe_status, .o_data_o, .o_data_oe_n, .o_clock_mode_pin_o,
        .o_clock_mode_pin_oe_n, .o_bus_error_pin_o, .o_bus_error_pin_oe_n, .o_board_reset_o,
        .o_board_reset_oe_n, .o_ram2_we_n, .o_ram1_we_n, .o_ram_oe_n, .o_rom_ce_n,
        .o_rom_we_n, .o_rom_oe_n, .o_rom_addr_hi, .o_fast_ram_cs_n,
        .o_mem_address_bit_nineteen, .o_error_indicator, .o_run_indicator,
        .o_latched_debug_out, .o_latched_debug_in);

    ebmrg_mcu_model mcu_u (.i_sys_clk(i_sys_clk), .i_data_o(o_data_o),
        .i_data_oe_n(o_data_oe_n), .o_bus(bus), .o_pipe_strobe(i_pipe_strobe),
        .o_pipe_status(i_pipe_status));

    // ========================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic sc_reset_data();
        i_reset_line_n = 1'h0;
        i_reset_data_cfg = 16'h00F0;
        i_clk_mode_low_cfg = 1'h1;
        step(1);
        chk("bus", bus, 16'h00F0);
        chk("clkmode_oe", o_clock_mode_pin_oe_n, 1'h0);
        chk("bus_error_pin_oe", o_bus_error_pin_oe_n, 1'h1);
        chk("pin_lvl", {o_clock_mode_pin_o, o_bus_error_pin_o, o_board_reset_o}, 3'h0);
        i_reset_data_cfg = 16'hA50F;
        i_clk_mode_low_cfg = 1'h0;
        i_bus_err_low_cfg = 1'h1;
        step(1);
        chk("bus", bus, 16'hA50F);
        chk("clkmode_oe", o_clock_mode_pin_oe_n, 1'h1);
        chk("bus_error_pin_oe", o_bus_error_pin_oe_n, 1'h0);
        chk("run_rst", o_run_indicator, 1'h0);
        i_reset_line_n = 1'h1;
        step(1);
        chk("bus_idle", o_data_oe_n, 16'hFFFF);
        chk("bus_error_pin_idle", o_bus_error_pin_oe_n, 1'h1);
    endtask

    task automatic sc_routing();
        logic [2:0] v;
        i_write_n = 1'h0;
        i_read_n = 1'h0;
        for (int k = 0; k < 8; k++) begin
            v = 3'(k);
            {i_cs0_we_en, i_cs3_we_en, i_cs5_oe_en} = {3{v[2]}};
            {i_chip_select_zero_n, i_chip_select_three_n, i_chip_select_five_n} = {3{v[1]}};
            {i_alt_ram2_we_n, i_alt_ram1_we_n, i_alt_ram_oe_n} = {3{v[0]}};
            {i_boot_chip_select_n, i_fast_ram_chip_select_n} = v[1:0];
            step(1);
            chk("rom_oe", o_rom_oe_n, v[1]);
            chk("ram2_we", o_ram2_we_n, v[2] ? v[1] : v[0]);
            chk("ram1_we", o_ram1_we_n, v[2] ? v[1] : v[0]);
            chk("ram_oe", o_ram_oe_n, v[2] ? v[1] : v[0]);
            chk("rom_ce", o_rom_ce_n, v[1]);
            chk("fast_cs", o_fast_ram_cs_n, v[0]);
        end
    endtask

    task automatic rom_wr(input logic [1:0] t, input logic p, input logic b, input logic e);
        i_memory_type_select = t;
        i_write_protect_en = p;
        i_bdm_active = b;
        i_boot_chip_select_n = 1'h0;
        i_write_n = 1'h0;
        step(1);
        chk("rom_we", o_rom_we_n, e);
    endtask

    task automatic sc_size_a19();
        logic [4:0] mask;
        i_memory_type_select = ebmrg_pkg::MTYPE_EPROM;
        i_addr_hi = 4'hF;
        i_address_bit_nineteen = 1'h1;
        for (int s = 0; s < 5; s++) begin
            i_memory_size_select = 3'(s);
            mask = 5'((1 << s) - 1);
            step(1);
            chk("rom_addr", o_rom_addr_hi, mask);
        end
        for (int d = 0; d < 2; d++) begin
            i_addr19_disconnect = d[0];
            step(1);
            chk("a19", o_mem_address_bit_nineteen, !d[0]);
        end
    endtask

    task automatic bad_cfg(input logic [1:0] t, input logic [2:0] s, input logic ins,
        input logic e);
        i_memory_type_select = t;
        i_memory_size_select = s;
        i_error_insertion_input_n = ins;
        step(1);
        chk("err_led", o_error_indicator, e | !ins);
        chk("brd_rst_oe", o_board_reset_oe_n, !e);
    endtask

    task automatic sc_run();
        i_reset_line_n = 1'h1;
        for (int k = 0; k < 3; k++) begin
            i_bdm_active = (k == 1);
            i_reset_line_n = (k != 2);
            step(1);
            chk("run", o_run_indicator, k == 0);
        end
    endtask

    task automatic pipe(input logic [1:0] b, input logic eo, input logic ei);
        mcu_u.pulse(b);
        step(1);
        chk("lat_out", o_latched_debug_out, eo);
        chk("lat_in", o_latched_debug_in, ei);
    endtask

    // ========================================
    // main sequence
    initial begin
        {i_rstn, i_reset_line_n, i_bdm_active, i_clk_mode_low_cfg, i_bus_err_low_cfg} = 5'h08;
        {i_cs0_we_en, i_cs3_we_en, i_cs5_oe_en, i_write_protect_en, i_addr19_disconnect} = 5'h1C;
        {i_chip_select_zero_n, i_chip_select_three_n, i_chip_select_five_n} = 3'h7;
        {i_boot_chip_select_n, i_fast_ram_chip_select_n, i_alt_ram2_we_n} = 3'h7;
        {i_alt_ram1_we_n, i_alt_ram_oe_n, i_write_n, i_read_n, i_error_insertion_input_n} = 5'h1F;
        {i_address_bit_nineteen, i_addr_hi, i_memory_size_select} = 8'h00;
        i_family = ebmrg_pkg::FAMILY_NARROW;
        i_memory_type_select = ebmrg_pkg::MTYPE_EPROM;
        i_reset_data_cfg = 16'h0000;
        step(10);
        chk("rst_oe", o_data_oe_n, 16'hFFFF);
        i_rstn = 1'h1;
        pipe(2'h1, 1'h1, 1'h0);
        pipe(2'h0, 1'h1, 1'h0);
        pipe(2'h0, 1'h0, 1'h0);
        pipe(2'h1, 1'h0, 1'h1);
        i_family = ebmrg_pkg::FAMILY_WIDE;
        pipe(2'h2, 1'h0, 1'h1);
        pipe(2'h1, 1'h1, 1'h0);
        sc_reset_data();
        sc_routing();
        rom_wr(ebmrg_pkg::MTYPE_FLASH, 1'h0, 1'h0, 1'h0);
        rom_wr(ebmrg_pkg::MTYPE_RAM, 1'h0, 1'h0, 1'h0);
        rom_wr(ebmrg_pkg::MTYPE_EPROM, 1'h0, 1'h1, 1'h1);
        rom_wr(ebmrg_pkg::MTYPE_FLASH, 1'h1, 1'h0, 1'h1);
        rom_wr(ebmrg_pkg::MTYPE_FLASH, 1'h1, 1'h1, 1'h0);
        sc_size_a19();
        bad_cfg(ebmrg_pkg::MTYPE_FLASH, 3'h2, 1'h1, 1'h0);
        bad_cfg(ebmrg_pkg::MTYPE_BAD, 3'h0, 1'h1, 1'h1);
        bad_cfg(ebmrg_pkg::MTYPE_RAM, 3'h1, 1'h1, 1'h1);
        bad_cfg(ebmrg_pkg::MTYPE_EPROM, 3'h5, 1'h1, 1'h1);
        bad_cfg(ebmrg_pkg::MTYPE_EPROM, 3'h4, 1'h0, 1'h0);
        sc_run();
        close_out();
    end
endmodule // tb_top

`default_nettype wire
